// ---- su0_fifo.sv ----
// su0_fifo: small valid/ready queue for transmit bytes
// assumes: single clock, synchronous active-high reset
`timescale 1ns/100ps

module su0_fifo
#(
   parameter int WIDTH = 8,  // word width
   parameter int DEPTH = 8   // number of words
)
(
   input  wire logic             clock,      // system clock
   input  wire logic             rst,        // sync reset, high
   input  wire logic             in_valid,   // producer has a word
   output      logic             in_ready,   // room for a word
   input  wire logic [WIDTH-1:0] in_data,    // word in
   output      logic             out_valid,  // word available
   input  wire logic             out_ready,  // consumer takes word
   output      logic [WIDTH-1:0] out_data    // word out
);

   localparam int AW = $clog2(DEPTH);  // pointer width

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;  // storage
      logic [AW-1:0]               wp;   // write pointer
      logic [AW-1:0]               rp;   // read pointer
      logic [AW:0]                 cnt;  // words held
   } su0_fifo_st_t;

   su0_fifo_st_t st_q;  // registered state
   su0_fifo_st_t st_d;  // next state
   logic         push;  // word accepted
   logic         pop;   // word taken

   // flags come from the count, so full and empty are exact
   assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_q.cnt != '0);
   assign out_data  = st_q.mem[st_q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // next-state logic: pointers wrap at depth
   always_comb
   begin
      st_d = st_q;
      if (push)
      begin
         st_d.mem[st_q.wp] = in_data;
         st_d.wp = (st_q.wp == AW'(DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
      end
      if (pop)
      begin
         st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
      end
      st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

endmodule

// ---- su0_pkg.sv ----
// su0_pkg: shared constants and types for the serial port zero uart
// assumes: one 40 MHz clock, synchronous special-function register port
package su0_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] SU0_CONTROL_ADDR = 8'h98;  // serial_zero_control
   localparam logic [7:0] SU0_DATA_ADDR    = 8'h99;  // data buffer address
   localparam logic [7:0] SU0_CTRL_RESET   = 8'h00;  // control reset value
   localparam logic [7:0] SU0_DATA_RESET   = 8'h00;  // receive buffer reset
   localparam logic [7:0] SU0_UNMAPPED     = 8'h00;  // read of other address

   // ----------------------------------------------------------------
   // bit timing, in peripheral clocks
   // ----------------------------------------------------------------
   localparam int SU0_M0_PER_SLOW = 12;  // mode 0, third mode bit 0
   localparam int SU0_M0_PER_FAST = 4;   // mode 0, third mode bit 1
   localparam int SU0_M2_PER_SLOW = 64;  // mode 2, doubling bit 0
   localparam int SU0_M2_PER_FAST = 32;  // mode 2, doubling bit 1
   localparam int SU0_OVS         = 16;  // oversampling ticks per bit
   localparam logic [3:0] SU0_M0_LIM_SLOW = 4'(SU0_M0_PER_SLOW - 1);
   localparam logic [3:0] SU0_M0_LIM_FAST = 4'(SU0_M0_PER_FAST - 1);
   localparam logic [3:0] SU0_M0_HALF_SLOW = 4'(SU0_M0_PER_SLOW / 2);
   localparam logic [3:0] SU0_M0_HALF_FAST = 4'(SU0_M0_PER_FAST / 2);
   localparam logic [1:0] SU0_PRE_SLOW = 2'(SU0_M2_PER_SLOW / SU0_OVS - 1);
   localparam logic [1:0] SU0_PRE_FAST = 2'(SU0_M2_PER_FAST / SU0_OVS - 1);
   localparam logic [3:0] SU0_OVS_LAST = 4'(SU0_OVS - 1);  // end of bit
   localparam logic [3:0] SU0_OVS_MID  = 4'(SU0_OVS / 2 - 1);  // sample

   // ----------------------------------------------------------------
   // frame shape
   // ----------------------------------------------------------------
   localparam logic [3:0] SU0_M0_BITS    = 4'd8;   // sync transfer length
   localparam logic [3:0] SU0_FRAME_10   = 4'd10;  // mode 1 frame
   localparam logic [3:0] SU0_FRAME_11   = 4'd11;  // mode 2 and 3 frame
   localparam logic [3:0] SU0_RX_LASTBIT = 4'd9;   // stop or ninth bit slot

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      SU0_MODE0 = 2'b00,  // synchronous shift
      SU0_MODE1 = 2'b01,  // 8-bit async, timer rate
      SU0_MODE2 = 2'b10,  // 9-bit async, fixed rate
      SU0_MODE3 = 2'b11   // 9-bit async, timer rate
   } su0_mode_t;

   typedef enum logic [1:0]
   {
      SU0_IDLE  = 2'b00,  // nothing in progress
      SU0_SYNC  = 2'b01,  // mode 0 transfer
      SU0_ASYNC = 2'b10   // framed transfer
   } su0_st_t;

   // control register, bit 7 first
   typedef struct packed
   {
      logic mode_select_bit_high;  // bit 7
      logic mode_select_bit_mid;   // bit 6
      logic third_mode_bit;        // bit 5
      logic rx_enable;             // bit 4
      logic ninth_transmit_bit;    // bit 3
      logic ninth_received_bit;    // bit 2
      logic transmit_done_flag;    // bit 1
      logic receive_done_flag;     // bit 0
   } su0_ctrl_t;

endpackage

// ---- su0_remote.sv ----
// su0_remote: remote serial device on the line side of the port
// assumes: the bench sets per and reads got, calls send and sync_rx
`timescale 1ns/100ps
module su0_remote
(
   input  wire logic clock, // system clock
   input  wire logic txd,   // line from the port
   input  wire logic rxo,   // mode 0 data from the port
   output      logic rxd    // line toward the port, idles at mark
);
   int          per = 64; // bit period in clocks, 0 stops collection
   logic [10:0] got[$];   // frames seen, start bit in bit 0
   logic [10:0] f;        // frame being collected
   initial rxd = 1'b1;
   // collect async frames, sampling each bit near its middle
   always
   begin
      wait (!txd && per > 8);
      repeat (per / 2) @(posedge clock);
      for (int i = 0; i < 11; i++)
      begin
         f[i] = txd;
         repeat (i < 10 ? per : 1) @(posedge clock);
      end
      got.push_back(f);
   end
   // send one frame, start bit first, stop bit last
   task send(input logic [10:0] fr);
      for (int i = 0; i < 11; i++)
      begin
         rxd = fr[i];
         repeat (per) @(negedge clock);
      end
   endtask
   // take mode 0 data on each rising shift clock
   task sync_rx(output logic [7:0] v);
      for (int i = 0; i < 8; i++)
         @(posedge txd) v[i] = rxo;
   endtask
endmodule

// ---- su0_uart.sv ----
// su0_uart: serial port zero, one sync shift mode and three async modes
// assumes: cpu special-function register port is synchronous to clock;
// timer overflow pulses and pin inputs are synchronous one-cycle signals
`timescale 1ns/100ps

module su0_uart
   import su0_pkg::*;
#(
   parameter int TX_DEPTH = 8  // transmit queue depth
)
(
   input  wire logic       clock,          // 40 MHz system clock
   input  wire logic       rst,            // sync reset, high
   input  wire logic       idle_mode,      // device idle, halts port
   input  wire logic [7:0] sfr_addr,       // register address
   input  wire logic       sfr_wr,         // register write strobe
   input  wire logic       sfr_rd,         // register read strobe
   input  wire logic [7:0] sfr_wdata,      // write data
   output      logic [7:0] sfr_rdata,      // read data, one cycle later
   input  wire logic       baud_doubling_bit, // rate doubling select
   input  wire logic       timer2_baud_sel,   // from timer_two_control
   input  wire logic       timer1_ovf,     // timer 1 overflow pulse
   input  wire logic       timer2_ovf,     // timer 2 overflow pulse
   output      logic       txd_out,        // transmit line or sync clock
   input  wire logic       rxd_in,         // receive pin level
   output      logic       rxd_out,        // receive pin drive, mode 0
   output      logic       rxd_oe,         // receive pin enable, mode 0
   output      logic       tx_queue_full   // transmit queue has no room
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      su0_ctrl_t   ctrl;     // serial_zero_control
      logic [7:0]  rbuf;     // receive buffer
      logic [7:0]  rdata;    // read data out
      logic        txd;      // txd pin
      logic        rxo;      // rxd drive value
      logic        rxoe;     // rxd drive enable
      logic        full;     // queue full copy
      logic [1:0]  pre;      // mode 2 prescaler
      logic        t1half;   // timer 1 halving toggle
      logic        rxprev;   // rxd last cycle
      su0_st_t     tx_st;    // transmitter state
      logic [10:0] tx_sh;    // transmit shifter
      logic [3:0]  tx_cnt;   // transmit bit index
      logic [3:0]  tx_ph;    // transmit tick phase
      logic [3:0]  tx_len;   // transmit frame length
      su0_st_t     rx_st;    // receiver state
      logic [8:0]  rx_sh;    // receive shifter
      logic [3:0]  rx_cnt;   // receive bit index
      logic [3:0]  rx_ph;    // receive tick phase
      logic [3:0]  m0_cnt;   // mode 0 clock counter
   } su0_st_s_t;

   su0_st_s_t  st_q;       // registered state
   su0_st_s_t  st_d;       // next state
   logic       pclk_en;    // peripheral clock running
   su0_mode_t  mode;       // current mode
   logic       tick16;     // oversampling tick
   logic       data_wr;    // cpu write to data address
   logic       q_ready;    // queue accepts a byte
   logic       q_valid;    // queue holds a byte
   logic       q_pop;      // transmitter takes a byte
   logic [7:0] q_data;     // head byte
   logic [3:0] m0_lim;     // mode 0 last count
   logic [3:0] m0_half;    // mode 0 clock rise
   logic [8:0] rx_new;     // shifter with current sample

   // ----------------------------------------------------------------
   // transmit queue
   // ----------------------------------------------------------------
   assign data_wr = sfr_wr && (sfr_addr == SU0_DATA_ADDR);

   su0_fifo
   #(
      .WIDTH (8),
      .DEPTH (TX_DEPTH)
   )
   u_txq
   (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (data_wr),
      .in_ready  (q_ready),
      .in_data   (sfr_wdata),
      .out_valid (q_valid),
      .out_ready (q_pop),
      .out_data  (q_data)
   );

   // ----------------------------------------------------------------
   // outputs straight from the state register
   // ----------------------------------------------------------------
   assign sfr_rdata     = st_q.rdata;
   assign txd_out       = st_q.txd;
   assign rxd_out       = st_q.rxo;
   assign rxd_oe        = st_q.rxoe;
   assign tx_queue_full = st_q.full;

   // ----------------------------------------------------------------
   // rate selection
   // ----------------------------------------------------------------
   assign pclk_en = !idle_mode;
   assign mode    = su0_mode_t'({st_q.ctrl.mode_select_bit_high,
                                 st_q.ctrl.mode_select_bit_mid});
   assign m0_lim  = st_q.ctrl.third_mode_bit ? SU0_M0_LIM_FAST
                                             : SU0_M0_LIM_SLOW;
   assign m0_half = st_q.ctrl.third_mode_bit ? SU0_M0_HALF_FAST
                                             : SU0_M0_HALF_SLOW;
   assign rx_new  = {rxd_in, st_q.rx_sh[8:1]};

   // oversampling tick: fixed divider in mode 2, timers in 1 and 3
   always_comb
   begin
      tick16 = 1'b0;
      if (pclk_en)
      begin
         unique case (mode)
            SU0_MODE2:  // fixed rate
            begin
               tick16 = (st_q.pre == (baud_doubling_bit ? SU0_PRE_FAST
                                                       : SU0_PRE_SLOW));
            end
            SU0_MODE1, SU0_MODE3:  // timer rate
            begin
               if (timer2_baud_sel)
               begin
                  tick16 = timer2_ovf;
               end
               else
               begin
                  tick16 = timer1_ovf && (baud_doubling_bit
                                          || st_q.t1half);
               end
            end
            SU0_MODE0:  // sync mode uses its own counter
            begin
               tick16 = 1'b0;
            end
         endcase
      end
   end

   // transmitter takes a byte only when idle and the clock runs
   assign q_pop = pclk_en && q_valid && (st_q.tx_st == SU0_IDLE)
                  && (st_q.rx_st != SU0_SYNC);

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      st_d        = st_q;
      st_d.full   = !q_ready;
      st_d.rxprev = rxd_in;

      // cpu write; hardware flag sets below win over a clear
      if (sfr_wr && (sfr_addr == SU0_CONTROL_ADDR))
      begin
         st_d.ctrl = su0_ctrl_t'(sfr_wdata);
      end

      // cpu read; receive buffer read does not touch transmit side
      if (sfr_rd)
      begin
         unique case (sfr_addr)
            SU0_CONTROL_ADDR: st_d.rdata = st_q.ctrl;
            SU0_DATA_ADDR:    st_d.rdata = st_q.rbuf;
            default:          st_d.rdata = SU0_UNMAPPED;
         endcase
      end

      // prescalers run only on the peripheral clock
      if (pclk_en)
      begin
         st_d.pre = tick16 ? 2'b00 : st_q.pre + 2'b01;
         if (timer1_ovf)
         begin
            st_d.t1half = !st_q.t1half;
         end
      end

      // ---------------- transmitter ----------------
      if (q_pop)
      begin
         st_d.tx_cnt = '0;
         st_d.tx_ph  = '0;
         st_d.m0_cnt = '0;
         // restart the fixed divider so the start bit gets a full period;
         // a receiver mid-frame only sees one tick moved by a few clocks
         st_d.pre    = '0;
         if (mode == SU0_MODE0)
         begin
            st_d.tx_st = SU0_SYNC;
            st_d.tx_sh = {3'b111, q_data};
         end
         else
         begin
            st_d.tx_st = SU0_ASYNC;
            // stop, ninth, data, start
            st_d.tx_sh = {1'b1, (mode == SU0_MODE1) ? 1'b1
                          : st_q.ctrl.ninth_transmit_bit,
                          q_data, 1'b0};
            st_d.tx_len = (mode == SU0_MODE1) ? SU0_FRAME_10
                                              : SU0_FRAME_11;
         end
      end
      else if (pclk_en)
      begin
         unique case (st_q.tx_st)
            SU0_IDLE:  // line rests high
            begin
               st_d.txd  = 1'b1;
               st_d.rxoe = 1'b0;
            end
            SU0_SYNC:  // shift out on rxd, clock on txd
            begin
               st_d.rxoe   = 1'b1;
               st_d.rxo    = st_q.tx_sh[0];
               st_d.txd    = (st_q.m0_cnt >= m0_half);
               st_d.m0_cnt = st_q.m0_cnt + 4'd1;
               if (st_q.m0_cnt == m0_lim)
               begin
                  st_d.m0_cnt = '0;
                  st_d.tx_sh  = {1'b1, st_q.tx_sh[10:1]};
                  st_d.tx_cnt = st_q.tx_cnt + 4'd1;
                  if (st_q.tx_cnt == SU0_M0_BITS - 4'd1)
                  begin
                     st_d.tx_st = SU0_IDLE;
                     st_d.ctrl.transmit_done_flag = 1'b1;
                  end
               end
            end
            SU0_ASYNC:  // framed send, 16 ticks a bit
            begin
               st_d.txd = st_q.tx_sh[0];
               if (tick16)
               begin
                  st_d.tx_ph = st_q.tx_ph + 4'd1;
                  if (st_q.tx_ph == SU0_OVS_LAST)
                  begin
                     st_d.tx_sh  = {1'b1, st_q.tx_sh[10:1]};
                     st_d.tx_cnt = st_q.tx_cnt + 4'd1;
                     // end of last data bit, stop bit follows
                     if (st_q.tx_cnt == st_q.tx_len - 4'd2)
                     begin
                        st_d.ctrl.transmit_done_flag = 1'b1;
                     end
                     if (st_q.tx_cnt == st_q.tx_len - 4'd1)
                     begin
                        st_d.tx_st = SU0_IDLE;  // stop bit done
                     end
                  end
               end
            end
            default:  // unused code returns to idle
            begin
               st_d.tx_st = SU0_IDLE;
            end
         endcase
      end

      // ---------------- receiver ----------------
      if (!st_q.ctrl.rx_enable)
      begin
         st_d.rx_st = SU0_IDLE;  // shift register disabled
      end
      else if (pclk_en)
      begin
         unique case (st_q.rx_st)
            SU0_IDLE:  // wait for start condition
            begin
               st_d.rx_cnt = '0;
               st_d.rx_ph  = '0;
               if (mode == SU0_MODE0)
               begin
                  // enable with flag clear starts a sync receive
                  if (!st_q.ctrl.receive_done_flag
                      && (st_q.tx_st == SU0_IDLE) && !q_valid)
                  begin
                     st_d.rx_st  = SU0_SYNC;
                     st_d.m0_cnt = '0;
                  end
               end
               else if (st_q.rxprev && !rxd_in)
               begin
                  st_d.rx_st = SU0_ASYNC;  // falling edge
               end
            end
            SU0_SYNC:  // clock out on txd, sample rxd on rise
            begin
               st_d.txd    = (st_q.m0_cnt >= m0_half);
               st_d.m0_cnt = st_q.m0_cnt + 4'd1;
               if (st_q.m0_cnt == m0_half)
               begin
                  st_d.rx_sh = rx_new;
               end
               if (st_q.m0_cnt == m0_lim)
               begin
                  st_d.m0_cnt = '0;
                  st_d.rx_cnt = st_q.rx_cnt + 4'd1;
                  if (st_q.rx_cnt == SU0_M0_BITS - 4'd1)
                  begin
                     st_d.rx_st = SU0_IDLE;
                     st_d.rbuf  = st_q.rx_sh[8:1];
                     st_d.ctrl.receive_done_flag = 1'b1;
                  end
               end
            end
            SU0_ASYNC:  // 16 ticks a bit, sample mid-bit
            begin
               if (tick16)
               begin
                  st_d.rx_ph = st_q.rx_ph + 4'd1;
                  if (st_q.rx_ph == SU0_OVS_MID)
                  begin
                     if (st_q.rx_cnt == '0)
                     begin
                        if (rxd_in)
                        begin
                           st_d.rx_st = SU0_IDLE;  // false start
                        end
                     end
                     else
                     begin
                        st_d.rx_sh = rx_new;
                        if (st_q.rx_cnt == SU0_RX_LASTBIT)
                        begin
                           st_d.rx_st = SU0_IDLE;
                           // stop bit (mode 1) or ninth bit
                           if (!st_q.ctrl.receive_done_flag
                               && (!st_q.ctrl.third_mode_bit
                                   || rx_new[8]))
                           begin
                              st_d.rbuf = rx_new[7:0];
                              st_d.ctrl.ninth_received_bit
                                 = rx_new[8];
                              st_d.ctrl.receive_done_flag
                                 = 1'b1;
                           end
                        end
                     end
                  end
                  if (st_q.rx_ph == SU0_OVS_LAST)
                  begin
                     st_d.rx_cnt = st_q.rx_cnt + 4'd1;
                  end
               end
            end
            default:  // unused code returns to idle
            begin
               st_d.rx_st = SU0_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_q        <= '0;
         st_q.ctrl   <= su0_ctrl_t'(SU0_CTRL_RESET);
         st_q.rbuf   <= SU0_DATA_RESET;
         st_q.txd    <= 1'b1;
         st_q.rxo    <= 1'b1;
         st_q.rxprev <= 1'b1;
         st_q.tx_st  <= SU0_IDLE;
         st_q.rx_st  <= SU0_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

endmodule

// ---- su0_uart_props.sv ----
// su0_uart_props: port-level checks for the serial port
// assumes: bound onto su0_uart, one clock, sync reset
`timescale 1ns/100ps
module su0_uart_props
   import su0_pkg::*;
(
   input wire logic       clock,             // system clock
   input wire logic       rst,               // sync reset
   input wire logic [7:0] sfr_addr,          // register address
   input wire logic       sfr_wr,            // write strobe
   input wire logic       sfr_rd,            // read strobe
   input wire logic [7:0] sfr_wdata,         // write data
   input wire logic [7:0] sfr_rdata,         // read data
   input wire logic       baud_doubling_bit, // rate doubling
   input wire logic       txd_out,           // serial line
   input wire logic       rxd_oe,            // mode 0 drive
   input wire logic       tx_queue_full      // queue full
);
   // ------------------------------------------------------------
   // helper state
   // ------------------------------------------------------------
   logic [7:0]  wq_q;  // last written control value
   logic [11:0] low_q; // cycles txd has been low
   logic        dw;    // data write
   logic        cr;    // control read
   assign dw = sfr_wr && sfr_addr == SU0_DATA_ADDR;
   assign cr = sfr_rd && sfr_addr == SU0_CONTROL_ADDR;
   // software control bits and low run length
   always_ff @(posedge clock)
   begin
      if (rst)
         wq_q <= SU0_CTRL_RESET;
      else if (sfr_wr && sfr_addr == SU0_CONTROL_ADDR)
         wq_q <= sfr_wdata;
      low_q <= (rst || txd_out) ? 12'h000 : low_q + 12'h001;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence line_up;
      $rose(txd_out);
   endsequence
   a_reset_idle: assert property (disable iff (1'b0)
      rst |=> txd_out && !rxd_oe && !tx_queue_full && sfr_rdata == 8'h00)
      else $error("reset state wrong");
   a_unmapped_zero: assert property (
      sfr_rd && sfr_addr != SU0_CONTROL_ADDR && sfr_addr != SU0_DATA_ADDR
      |=> sfr_rdata == SU0_UNMAPPED) else $error("unmapped read not zero");
   a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved");
   a_ctrl_readback: assert property (cr |=> sfr_rdata[7:3] ==
      $past(wq_q[7:3])) else $error("control bits lost");
   a_m2_bit_len: assert property (wq_q[7:6] == 2'b10 ##0 line_up
      |-> low_q != 12'h000 && (low_q & (baud_doubling_bit ? 12'h01F :
      12'h03F)) == 12'h000) else $error("mode 2 bit length wrong");
   a_m0_half_len: assert property (wq_q[7:6] == 2'b00 ##0 line_up
      |-> low_q == (wq_q[5] ? 12'h002 : 12'h006))
      else $error("mode 0 clock phase wrong");
   a_oe_mode0: assert property (rxd_oe |-> wq_q[7:6] == 2'b00)
      else $error("receive pin driven outside mode 0");
   a_full_cause: assert property ($rose(tx_queue_full)
      |-> $past(dw) || $past(dw, 2)) else $error("full without write");
endmodule
bind su0_uart su0_uart_props u_su0_uart_props (.clock, .rst, .sfr_addr,
   .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .baud_doubling_bit,
   .txd_out, .rxd_oe, .tx_queue_full);

// ---- su0_uart_tb.sv ----
// su0_uart_tb: self-checking bench for the serial port
// assumes: su0_remote on the line side, tov drives both timer overflow inputs
`timescale 1ns/100ps
module su0_uart_tb
   import su0_pkg::*;
;
   logic        clock = 1'b0;        // 40 MHz clock
   logic        rst = 1'b1;          // sync reset
   logic [7:0]  sfr_addr, sfr_wdata; // bus address and data
   logic        sfr_wr, sfr_rd;      // bus strobes
   logic [7:0]  sfr_rdata, d;        // read data
   logic        txd_out, rxd_out, rxd_oe, rxd_rem, rxd_line, tx_queue_full;
   logic        idle_mode = 1'b0, timer2_baud_sel = 1'b0, tov = 1'b0;
   int          err_total = 0;       // mismatches
   int          samples_checked = 0; // comparisons
   // control, data, ninth, expected buffer, expected control
   logic [39:0] tbl [4] = '{40'h903C013C95, 40'hB05A003CB0,
                            40'hB05A015AB5, 40'h8077015A80};
   always #12.5 clock = ~clock;
   // timer overflow pulse on every other clock
   always @(negedge clock) tov <= !tov;
   assign rxd_line = rxd_oe ? rxd_out : rxd_rem;
   su0_uart u_su0_uart (.clock, .rst, .idle_mode, .sfr_addr,
      .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .baud_doubling_bit(1'b0),
      .timer2_baud_sel, .timer1_ovf(tov), .timer2_ovf(tov),
      .txd_out, .rxd_in(rxd_line), .rxd_out, .rxd_oe, .tx_queue_full);
   su0_remote u_su0_remote (.clock, .txd(txd_out), .rxo(rxd_out),
      .rxd(rxd_rem));
   task chk(input logic [10:0] seen, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clock);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge clock);
      sfr_wr = 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(negedge clock);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clock);
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask
   task t_reset;
      rd(SU0_CONTROL_ADDR);
      chk(d, SU0_CTRL_RESET);
      rd(SU0_DATA_ADDR);
      chk(d, SU0_DATA_RESET);
      rd(8'h9A);
      chk(d, SU0_UNMAPPED);
   endtask
   // fill the queue, overflow it, drain through the remote
   task t_m2_tx;
      wr(SU0_CONTROL_ADDR, 8'h88);
      for (int k = 0; k < 9; k++)
         wr(SU0_DATA_ADDR, 8'hA5 + 8'(k));
      repeat (3) @(negedge clock);
      chk(tx_queue_full, 1'b1);
      wr(SU0_DATA_ADDR, 8'hEE);
      for (int i = 0; i < 8000 && u_su0_remote.got.size() < 9; i++)
         @(posedge clock);
      repeat (800) @(negedge clock);
      chk(11'(u_su0_remote.got.size()), 11'h009);
      chk(u_su0_remote.got[0], {2'b11, 8'hA5, 1'b0});
      chk(u_su0_remote.got[8], {2'b11, 8'hAD, 1'b0});
      chk(tx_queue_full, 1'b0);
      rd(SU0_CONTROL_ADDR);
      chk(d, 8'h8A);
      rd(SU0_DATA_ADDR);
      chk(d, SU0_DATA_RESET);
   endtask
   // enable, multiprocessor refusal and acceptance, disable
   task t_rx;
      for (int j = 0; j < 4; j++)
      begin
         wr(SU0_CONTROL_ADDR, tbl[j][39:32]);
         u_su0_remote.send({1'b1, tbl[j][16], tbl[j][31:24], 1'b0});
         rd(SU0_DATA_ADDR);
         chk(d, tbl[j][15:8]);
         rd(SU0_CONTROL_ADDR);
         chk(d, tbl[j][7:0]);
      end
   endtask
   // mode 1 send on timer 2 pulses, 32-clock bits
   task t_m1;
      timer2_baud_sel = 1'b1;
      u_su0_remote.per = 32;
      wr(SU0_CONTROL_ADDR, 8'h40);
      wr(SU0_DATA_ADDR, 8'h3C);
      repeat (400) @(negedge clock);
      chk(u_su0_remote.got[9], {2'b11, 8'h3C, 1'b0});
   endtask
   task t_m0;
      u_su0_remote.per = 0;
      wr(SU0_CONTROL_ADDR, 8'h20);
      idle_mode = 1'b1;
      wr(SU0_DATA_ADDR, 8'hC3);
      repeat (20) @(negedge clock);
      chk(rxd_oe, 1'b0);
      idle_mode = 1'b0;
      u_su0_remote.sync_rx(d);
      chk(d, 8'hC3);
      repeat (8) @(negedge clock);
      rd(SU0_CONTROL_ADDR);
      chk(d, 8'h22);
      wr(SU0_CONTROL_ADDR, 8'h30);
      repeat (40) @(negedge clock);
      rd(SU0_DATA_ADDR);
      chk(d, 8'hFF);
      rd(SU0_CONTROL_ADDR);
      chk(d, 8'h31);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      t_reset;
      t_m2_tx;
      t_rx;
      t_m1;
      t_m0;
      finish_test;
   end
   // cut a hang short
   initial
   begin
      repeat (30000) @(posedge clock);
      err_total++;
      finish_test;
   end
endmodule
